/* File: rss_pkg.sv */
// constants and types for the reset source supervisor
package rss_pkg;

    // ==========================================================
    // register map
    localparam logic [3:0] SUPPLY_MONITOR_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] RESET_CAUSE_REGISTER_OFFSET = 4'h4;

    // ==========================================================
    // supply monitor control fields
    localparam int CORE_MONITOR_ENABLE_BIT = 7;
    localparam int CORE_SUPPLY_ABOVE_RESET_BIT = 6;
    localparam int CORE_SUPPLY_WARNING_OK_BIT = 5;
    localparam int BATTERY_WARNING_OK_BIT = 4;
    localparam int CORE_WARNING_IRQ_ENABLE_BIT = 3;
    localparam int BATTERY_WARNING_IRQ_ENABLE_BIT = 2;

    // ==========================================================
    // reset cause register fields
    localparam int COMPARATOR_RESET_ENABLE_FLAG_BIT = 5;
    localparam int CLOCK_LOSS_ENABLE_FLAG_BIT = 2;
    localparam int POWER_FAIL_RESET_ENABLE_FLAG_BIT = 1;
    localparam int PIN_RESET_FLAG_BIT = 0;

    // ==========================================================
    // reset values
    localparam logic CORE_MONITOR_ENABLE_RESET = 1'b1;
    localparam logic CORE_WARNING_IRQ_ENABLE_RESET = 1'b1;
    localparam logic BATTERY_WARNING_IRQ_ENABLE_RESET = 1'b0;
    localparam logic POWER_FAIL_SELECT_RESET = 1'b1;
    localparam logic POWER_FAIL_FLAG_RESET = 1'b1;
    localparam logic CLOCK_LOSS_ENABLE_RESET = 1'b0;
    localparam logic COMPARATOR_RESET_ENABLE_RESET = 1'b0;

    // ==========================================================
    // timing
    localparam int SYSCLK_PERIOD_PS = 25000;
    localparam int CLOCK_LOSS_TIME_US = 100;
    localparam logic [12:0] CLOCK_LOSS_CYCLES =
        13'(CLOCK_LOSS_TIME_US * 1000000 / SYSCLK_PERIOD_PS);
    localparam logic [12:0] STUCK_COUNT_MAX = 13'h1fff;
    localparam logic [3:0] RESET_STRETCH_CYCLES = 4'h8;

    // ==========================================================
    // axi responses
    localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        RSS_RUN = 2'b00,
        RSS_HOLD = 2'b01,
        RSS_RELEASE = 2'b10
    } rss_phase_type;

    typedef enum logic [1:0] {
        RSS_CAUSE_SUPPLY = 2'b00,
        RSS_CAUSE_PIN = 2'b01,
        RSS_CAUSE_CLOCK = 2'b10,
        RSS_CAUSE_COMPARATOR = 2'b11
    } rss_cause_type;

    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic vdd_s1;
        logic vdd_s2;
        logic warn_s1;
        logic warn_s2;
        logic warn_s3;
        logic bat_s1;
        logic bat_s2;
        logic bat_s3;
        logic cmp_s1;
        logic cmp_s2;
        logic mclk_s1;
        logic mclk_s2;
        logic mclk_s3;
        logic [12:0] stuck_cnt;
        logic core_monitor_enable;
        logic core_warning_irq_enable;
        logic battery_warning_irq_enable;
        logic power_fail_select;
        logic clock_loss_enable;
        logic comparator_reset_enable;
        logic pin_reset_flag;
        logic power_fail_flag;
        logic clock_loss_flag;
        logic comparator_flag;
        rss_phase_type phase;
        rss_cause_type cause;
        logic [3:0] stretch;
        logic system_reset;
        logic reset_pin_out;
        logic reset_pin_oe_n;
        logic core_warning_irq;
        logic battery_warning_irq;
        logic awready;
        logic aw_hold;
        logic [3:0] aw_addr;
        logic wready;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rss_state_type;

endpackage : rss_pkg

/* File: rss_reset_source_supervisor.sv */
// reset source supervisor: supply monitor, pin, clock loss and comparator resets
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module rss_reset_source_supervisor #(
    parameter bit HAS_BATTERY_MONITOR = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    input wire logic core_supply_above_reset,
    input wire logic core_supply_warning_ok,
    input wire logic battery_warning_ok,
    input wire logic comparator_output,
    input wire logic monitored_clock,
    input wire logic low_power_mode,
    input wire logic comparator_wake_enable,
    output logic system_reset,
    output logic core_warning_irq,
    output logic battery_warning_irq
);

    rss_pkg::rss_state_type s;
    rss_pkg::rss_state_type next_s;

    // ==========================================================
    // request and register helpers
    logic req_supply;
    logic req_pin;
    logic req_clock;
    logic req_cmp;
    logic any_req;
    logic core_ie_eff;
    logic bat_ie_eff;
    logic [7:0] control_read;
    logic [7:0] cause_read;
    logic [31:0] read_word;
    logic read_hit;
    logic write_hit_ctrl;
    logic write_hit_cause;

    // effective interrupt enables per variant
    assign core_ie_eff = s.core_warning_irq_enable | ~HAS_BATTERY_MONITOR;
    assign bat_ie_eff = s.battery_warning_irq_enable & HAS_BATTERY_MONITOR;

    // reset requests from synchronised sources
    assign req_supply = s.core_monitor_enable & s.power_fail_select
        & ~s.vdd_s2 & ~low_power_mode;
    assign req_pin = ~s.pin_s2
        & ~(s.phase == rss_pkg::RSS_HOLD && s.cause == rss_pkg::RSS_CAUSE_SUPPLY);
    assign req_clock = s.clock_loss_enable & ~low_power_mode
        & (s.stuck_cnt > rss_pkg::CLOCK_LOSS_CYCLES);
    assign req_cmp = s.comparator_reset_enable & ~s.cmp_s2
        & (~low_power_mode | comparator_wake_enable);
    assign any_req = req_supply | req_pin | req_clock | req_cmp;

    // readable register images
    assign control_read = {
        s.core_monitor_enable,
        s.vdd_s2,
        s.warn_s2,
        s.bat_s2 & HAS_BATTERY_MONITOR,
        s.core_warning_irq_enable,
        s.battery_warning_irq_enable,
        2'h0
    };
    assign cause_read = {
        2'h0,
        s.comparator_flag,
        2'h0,
        s.clock_loss_flag,
        s.power_fail_flag,
        s.pin_reset_flag
    };

    // read decode
    always_comb begin
        read_hit = 1'b1;
        read_word = 32'h0;
        if (s_axi_araddr == rss_pkg::SUPPLY_MONITOR_CONTROL_OFFSET) begin
            read_word = {24'h0, control_read};
        end else if (s_axi_araddr == rss_pkg::RESET_CAUSE_REGISTER_OFFSET) begin
            read_word = {24'h0, cause_read};
        end else begin
            read_hit = 1'b0;
        end
    end

    // write decode on held address
    assign write_hit_ctrl = s.aw_addr == rss_pkg::SUPPLY_MONITOR_CONTROL_OFFSET;
    assign write_hit_cause = s.aw_addr == rss_pkg::RESET_CAUSE_REGISTER_OFFSET;

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;

        // two-stage synchronisers, third stage for edge detection
        next_s.pin_s1 = reset_pin_in;
        next_s.pin_s2 = s.pin_s1;
        next_s.vdd_s1 = core_supply_above_reset;
        next_s.vdd_s2 = s.vdd_s1;
        next_s.warn_s1 = core_supply_warning_ok;
        next_s.warn_s2 = s.warn_s1;
        next_s.warn_s3 = s.warn_s2;
        next_s.bat_s1 = battery_warning_ok;
        next_s.bat_s2 = s.bat_s1;
        next_s.bat_s3 = s.bat_s2;
        next_s.cmp_s1 = comparator_output;
        next_s.cmp_s2 = s.cmp_s1;
        next_s.mclk_s1 = monitored_clock;
        next_s.mclk_s2 = s.mclk_s1;
        next_s.mclk_s3 = s.mclk_s2;

        // count cycles since the monitored clock last changed level
        if (s.mclk_s2 != s.mclk_s3) begin
            next_s.stuck_cnt = 13'h0;
        end else if (s.stuck_cnt != rss_pkg::STUCK_COUNT_MAX) begin
            next_s.stuck_cnt = s.stuck_cnt + 13'h1;
        end

        // warning interrupts on falling status
        next_s.core_warning_irq = s.warn_s3 & ~s.warn_s2 & core_ie_eff;
        next_s.battery_warning_irq = s.bat_s3 & ~s.bat_s2 & bat_ie_eff;

        // write channel capture
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_hold = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_hold = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // perform write once address and data are both held
        if (s.aw_hold && s.w_hold && !s.bvalid) begin
            next_s.aw_hold = 1'b0;
            next_s.w_hold = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = (write_hit_ctrl || write_hit_cause)
                ? rss_pkg::AXI_RESP_OKAY : rss_pkg::AXI_RESP_SLVERR;
            if (write_hit_ctrl && s.w_strb[0]) begin
                next_s.core_monitor_enable =
                    s.w_data[rss_pkg::CORE_MONITOR_ENABLE_BIT];
                next_s.core_warning_irq_enable =
                    s.w_data[rss_pkg::CORE_WARNING_IRQ_ENABLE_BIT];
                next_s.battery_warning_irq_enable =
                    s.w_data[rss_pkg::BATTERY_WARNING_IRQ_ENABLE_BIT];
            end
            if (write_hit_cause && s.w_strb[0]) begin
                next_s.power_fail_select =
                    s.w_data[rss_pkg::POWER_FAIL_RESET_ENABLE_FLAG_BIT];
                next_s.clock_loss_enable =
                    s.w_data[rss_pkg::CLOCK_LOSS_ENABLE_FLAG_BIT];
                next_s.comparator_reset_enable =
                    s.w_data[rss_pkg::COMPARATOR_RESET_ENABLE_FLAG_BIT];
            end
        end
        next_s.awready = !next_s.aw_hold && !next_s.bvalid;
        next_s.wready = !next_s.w_hold && !next_s.bvalid;

        // read channel
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = read_word;
            next_s.rresp = read_hit ? rss_pkg::AXI_RESP_OKAY : rss_pkg::AXI_RESP_SLVERR;
        end
        next_s.arready = !next_s.rvalid;

        // reset sequencing
        unique case (s.phase)
            rss_pkg::RSS_RUN: begin
                if (any_req) begin
                    next_s.phase = rss_pkg::RSS_HOLD;
                    next_s.stretch = rss_pkg::RESET_STRETCH_CYCLES;
                    if (req_supply) begin
                        next_s.cause = rss_pkg::RSS_CAUSE_SUPPLY;
                    end else if (req_pin) begin
                        next_s.cause = rss_pkg::RSS_CAUSE_PIN;
                    end else if (req_clock) begin
                        next_s.cause = rss_pkg::RSS_CAUSE_CLOCK;
                    end else begin
                        next_s.cause = rss_pkg::RSS_CAUSE_COMPARATOR;
                    end
                end
            end
            rss_pkg::RSS_HOLD: begin
                if (any_req) begin
                    next_s.stretch = rss_pkg::RESET_STRETCH_CYCLES;
                end else if (s.stretch != 4'h0) begin
                    next_s.stretch = s.stretch - 4'h1;
                end else begin
                    next_s.phase = rss_pkg::RSS_RELEASE;
                end
            end
            rss_pkg::RSS_RELEASE: begin
                // cause flags written on exit, hardware over software
                next_s.pin_reset_flag = s.cause == rss_pkg::RSS_CAUSE_PIN;
                next_s.clock_loss_flag = s.cause == rss_pkg::RSS_CAUSE_CLOCK;
                next_s.comparator_flag = s.cause == rss_pkg::RSS_CAUSE_COMPARATOR;
                next_s.power_fail_flag = s.cause == rss_pkg::RSS_CAUSE_SUPPLY;
                if (s.cause == rss_pkg::RSS_CAUSE_SUPPLY) begin
                    next_s.core_monitor_enable = 1'b1;
                    next_s.power_fail_select = 1'b1;
                end
                next_s.phase = rss_pkg::RSS_RUN;
            end
            default: begin
                next_s.phase = rss_pkg::RSS_RUN;
            end
        endcase

        // registered outputs
        next_s.system_reset = next_s.phase != rss_pkg::RSS_RUN;
        next_s.reset_pin_out = 1'b0;
        next_s.reset_pin_oe_n = !(next_s.phase == rss_pkg::RSS_HOLD
            && next_s.cause == rss_pkg::RSS_CAUSE_SUPPLY && req_supply);
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.pin_s1 <= 1'b1;
            s.pin_s2 <= 1'b1;
            s.vdd_s1 <= 1'b1;
            s.vdd_s2 <= 1'b1;
            s.warn_s1 <= 1'b1;
            s.warn_s2 <= 1'b1;
            s.warn_s3 <= 1'b1;
            s.bat_s1 <= 1'b1;
            s.bat_s2 <= 1'b1;
            s.bat_s3 <= 1'b1;
            s.cmp_s1 <= 1'b1;
            s.cmp_s2 <= 1'b1;
            s.core_monitor_enable <= rss_pkg::CORE_MONITOR_ENABLE_RESET;
            s.core_warning_irq_enable <= rss_pkg::CORE_WARNING_IRQ_ENABLE_RESET;
            s.battery_warning_irq_enable <= rss_pkg::BATTERY_WARNING_IRQ_ENABLE_RESET;
            s.power_fail_select <= rss_pkg::POWER_FAIL_SELECT_RESET;
            s.power_fail_flag <= rss_pkg::POWER_FAIL_FLAG_RESET;
            s.clock_loss_enable <= rss_pkg::CLOCK_LOSS_ENABLE_RESET;
            s.comparator_reset_enable <= rss_pkg::COMPARATOR_RESET_ENABLE_RESET;
            s.phase <= rss_pkg::RSS_RUN;
            s.cause <= rss_pkg::RSS_CAUSE_SUPPLY;
            s.reset_pin_oe_n <= 1'b1;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign reset_pin_out = s.reset_pin_out;
    assign reset_pin_oe_n = s.reset_pin_oe_n;
    assign system_reset = s.system_reset;
    assign core_warning_irq = s.core_warning_irq;
    assign battery_warning_irq = s.battery_warning_irq;

endmodule : rss_reset_source_supervisor

`default_nettype wire

/* File: rss_checker_assertions.sv */
// port assertions for the reset source supervisor
`timescale 1ns/1ps
`default_nettype none
module rss_checker #(
    parameter bit HAS_BATTERY_MONITOR = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic reset_pin_in,
    input wire logic reset_pin_oe_n,
    input wire logic core_supply_above_reset,
    input wire logic system_reset,
    input wire logic core_warning_irq,
    input wire logic battery_warning_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [4:0] up_cnt;
    // ==========================================
    // cycles since the core supply was last low, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn || !core_supply_above_reset) begin
            up_cnt <= 5'h00;
        end else if (up_cnt != 5'h1f) begin
            up_cnt <= up_cnt + 5'h01;
        end
    end
    // ==========================================
    // assertions
    a_pin_holds_reset: assert property ((!reset_pin_in && reset_pin_oe_n) [*6] |-> system_reset)
        else $error("pin held low without system reset");
    a_stretch_min: assert property ($rose(system_reset) |-> system_reset [*8])
        else $error("system reset shorter than the stretch");
    a_pin_not_driven: assert property (up_cnt >= 5'h14 |-> reset_pin_oe_n)
        else $error("reset pin driven without a supply reset");
    a_irq_pulse: assert property (core_warning_irq |=> !core_warning_irq)
        else $error("warning interrupt longer than one cycle");
    a_batt_irq_off: assert property (!HAS_BATTERY_MONITOR |-> !battery_warning_irq)
        else $error("battery interrupt on a variant without it");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after the request");
    a_bvalid_blocks: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted during a response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after the request");
    a_rvalid_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted during read data");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
endmodule : rss_checker
bind rss_reset_source_supervisor rss_checker #(.HAS_BATTERY_MONITOR(HAS_BATTERY_MONITOR)) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .reset_pin_in, .reset_pin_oe_n, .core_supply_above_reset, .system_reset,
    .core_warning_irq, .battery_warning_irq);
`default_nettype wire

/* File: rss_far_side_model.sv */
// far side model: pulled-up reset pin and the monitored system clock
`timescale 1ns/1ps
`default_nettype none
module rss_far_side_model (
    input wire logic aclk,
    input wire logic ext_pin_low,
    input wire logic clock_run,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    output logic reset_pin_in,
    output logic monitored_clock
);
    logic [1:0] div = 2'h0;
    // pin pulled up, low while either party pulls it down
    assign reset_pin_in = !(ext_pin_low || (!reset_pin_oe_n && !reset_pin_out));
    // clock stands at its last level while stopped
    always_ff @(posedge aclk) begin
        if (clock_run) begin
            div <= div + 2'h1;
        end
    end
    assign monitored_clock = div[1];
endmodule : rss_far_side_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the reset source supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [3:0] CTRL = rss_pkg::SUPPLY_MONITOR_CONTROL_OFFSET;
    localparam logic [3:0] CAUSE = rss_pkg::RESET_CAUSE_REGISTER_OFFSET;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic reset_pin_in, reset_pin_out, reset_pin_oe_n, monitored_clock;
    logic core_supply_above_reset = 1'b1, core_supply_warning_ok = 1'b1;
    logic battery_warning_ok = 1'b1, comparator_output = 1'b1;
    logic low_power_mode = 1'b0, comparator_wake_enable = 1'b0;
    logic system_reset, core_warning_irq, battery_warning_irq;
    logic ext_pin_low = 1'b0, clock_run = 1'b1;
    int error_cnt = 0, n_checks = 0, cyc = 0, irqs = 0, n;
    rss_reset_source_supervisor #(.HAS_BATTERY_MONITOR(1'b0)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_in, .reset_pin_out,
        .reset_pin_oe_n, .core_supply_above_reset, .core_supply_warning_ok,
        .battery_warning_ok, .comparator_output, .monitored_clock, .low_power_mode,
        .comparator_wake_enable, .system_reset, .core_warning_irq, .battery_warning_irq);
    rss_far_side_model far (.aclk, .ext_pin_low, .clock_run, .reset_pin_out,
        .reset_pin_oe_n, .reset_pin_in, .monitored_clock);
    // ==========================================
    // clock, watchdog and interrupt count
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (core_warning_irq === 1'b1) irqs++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task conclude;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    // write with address and data offered together
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_p, w_p, b_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        b_p = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p || b_p) begin
            @(posedge aclk);
            if (b_p && !aw_p && !w_p && s_axi_bvalid === 1'b1) begin
                b_p = 1'b0;
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
            if (aw_p && s_axi_awready === 1'b1) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (w_p && s_axi_wready === 1'b1) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
    endtask : wr
    task rdr(input logic [3:0] a);
        logic ar_p, r_p;
        ar_p = 1'b1;
        r_p = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (ar_p || r_p) begin
            @(posedge aclk);
            if (r_p && !ar_p && s_axi_rvalid === 1'b1) begin
                r_p = 1'b0;
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
            if (ar_p && s_axi_arready === 1'b1) begin
                ar_p = 1'b0;
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end
    endtask : rdr
    // bounded wait for system reset to reach a level
    task wait_rst(input logic lvl, input int lim);
        n = 0;
        while (system_reset !== lvl && n < lim) begin
            @(posedge aclk);
            n++;
        end
        check("reset wait", 32'h1, 32'(n < lim));
    endtask : wait_rst
    // ==========================================
    // test sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(CTRL); check("control", 32'he8, rd);
        rdr(CAUSE); check("cause", 32'h02, rd);
        $display("test reset values done");
        core_supply_warning_ok <= 1'b0;
        repeat (12) @(posedge aclk);
        check("irq count", 32'h1, 32'(irqs));
        rdr(CTRL); check("control", 32'hc8, rd);
        wr(CTRL, 32'h03);
        rdr(CTRL); check("control", 32'h40, rd);
        core_supply_warning_ok <= 1'b1;
        repeat (10) @(posedge aclk);
        core_supply_warning_ok <= 1'b0;
        repeat (10) @(posedge aclk);
        check("irq count", 32'h2, 32'(irqs));
        core_supply_warning_ok <= 1'b1;
        core_supply_above_reset <= 1'b0;
        repeat (20) @(posedge aclk);
        check("reset", 32'h0, 32'(system_reset));
        rdr(CTRL); check("control", 32'h20, rd);
        core_supply_above_reset <= 1'b1;
        wr(4'h8, 32'h00); check("resp", 32'h2, 32'(resp));
        rdr(4'h8); check("unmapped", 32'h0, rd);
        check("rresp", 32'h2, 32'(resp));
        $display("test control register done");
        wr(CTRL, 32'h88);
        core_supply_above_reset <= 1'b0;
        wait_rst(1'b1, 20);
        repeat (2) @(posedge aclk);
        check("pin", 32'h0, 32'(reset_pin_in));
        core_supply_above_reset <= 1'b1;
        wait_rst(1'b0, 40);
        rdr(CAUSE); check("cause", 32'h02, rd);
        low_power_mode <= 1'b1;
        ext_pin_low <= 1'b1;
        repeat (30) @(posedge aclk);
        check("reset", 32'h1, 32'(system_reset));
        ext_pin_low <= 1'b0;
        low_power_mode <= 1'b0;
        wait_rst(1'b0, 40);
        rdr(CAUSE); check("cause", 32'h01, rd);
        $display("test supply and pin done");
        wr(CAUSE, 32'h06);
        low_power_mode <= 1'b1;
        clock_run <= 1'b0;
        repeat (4200) @(posedge aclk);
        check("reset", 32'h0, 32'(system_reset));
        low_power_mode <= 1'b0;
        wait_rst(1'b1, 20);
        clock_run <= 1'b1;
        wait_rst(1'b0, 40);
        rdr(CAUSE); check("cause", 32'h04, rd);
        clock_run <= 1'b0;
        wait_rst(1'b1, 4100);
        check("loss time", 32'h1, 32'(n > 3999 && n < 4016));
        clock_run <= 1'b1;
        wait_rst(1'b0, 40);
        wr(CAUSE, 32'h02);
        $display("test clock loss done");
        wr(CAUSE, 32'h22);
        low_power_mode <= 1'b1;
        comparator_output <= 1'b0;
        repeat (30) @(posedge aclk);
        check("reset", 32'h0, 32'(system_reset));
        comparator_wake_enable <= 1'b1;
        wait_rst(1'b1, 20);
        check("pin", 32'h1, 32'(reset_pin_in));
        comparator_output <= 1'b1;
        low_power_mode <= 1'b0;
        wait_rst(1'b0, 40);
        rdr(CAUSE); check("cause", 32'h20, rd);
        $display("test comparator done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
